//--- inc/tssp_if.sv
// Two-wire link between the sensor port and its bus master.
// Both lines are open drain with a pull-up; the levels are resolved here.
`timescale 1ns/10ps
interface tssp_if;
    logic sclOut;
    logic sclOe;
    logic sdaHostOut;
    logic sdaHostOe;
    logic sdaDevOut;
    logic sdaDevOe;
    logic scl;
    logic sda;

    assign scl = !(sclOe && !sclOut);
    assign sda = !((sdaHostOe && !sdaHostOut) || (sdaDevOe && !sdaDevOut));

    modport host (output sclOut, output sclOe, output sdaHostOut, output sdaHostOe,
        input scl, input sda);
    modport device (output sdaDevOut, output sdaDevOe, input scl, input sda);
endinterface

//--- inc/tssp_pkg.sv
// Constants shared by both ends of the two-wire temperature sensor port.
// Assumes a 25 MHz mclk on both ends.
package tssp_pkg;
    localparam logic [3:0] ADDR_FIXED = 4'h9;
    localparam logic [1:0] PTR_TEMP = 2'h0;
    localparam logic [1:0] PTR_SET = 2'h1;
    localparam logic [1:0] PTR_HYST = 2'h2;
    localparam logic [1:0] PTR_UPPER = 2'h3;
    localparam logic [15:0] REG16_RST = 16'h0000;
    localparam logic [7:0] REG8_RST = 8'h00;
    localparam logic [1:0] PTR_RST = 2'h0;
    localparam int RES_POS = 5;
    localparam logic [3:0] BIT_LAST = 4'h8;
    localparam logic [3:0] ACKED_MARK = 4'h9;
    localparam int CLK_NS = 40;
    localparam int CONV_MIN_MS = 30;
    localparam int CONV_MAX_MS = 240;
    localparam int CONV_MIN_CYC = CONV_MIN_MS * 1000000 / CLK_NS;
    localparam int CONV_MAX_CYC = CONV_MAX_MS * 1000000 / CLK_NS;
    localparam int SCL_PERIOD_NS = 10000;
    localparam int SCL_QUARTER_CYC = (SCL_PERIOD_NS + 4 * CLK_NS - 1) / (4 * CLK_NS);
    localparam logic [7:0] WB_CTRL = 8'h00;
    localparam logic [7:0] WB_TARGET = 8'h04;
    localparam logic [7:0] WB_WDATA = 8'h08;
    localparam logic [7:0] WB_RDATA = 8'h0C;
    localparam logic [7:0] WB_STATUS = 8'h10;
    localparam int CTRL_GO = 0;
    localparam int CTRL_READ = 1;
    localparam int CTRL_PTR = 2;
    localparam int CTRL_CNT = 3;
    localparam int TGT_PTR = 8;
    localparam int STAT_BUSY = 0;
    localparam int STAT_NAK = 1;
endpackage

//--- src/tssp_device.sv
// Device end: serial slave port, register set, conversion timer and alert.
// Assumes scl/sda come from the bus master asynchronously; converter data is
// on the mclk domain and is sampled at the end of each conversion period.
`timescale 1ns/10ps
module tssp_device #(
    parameter int CONV_BASE_CYC = tssp_pkg::CONV_MIN_CYC
) (
    input wire logic mclk,
    input wire logic sys_rst,
    tssp_if.device link,
    input wire logic [2:0] addrSelect,
    input wire logic [15:0] convData,
    output logic convStrobe,
    output logic alert,
    output logic [7:0] settings
);
    typedef enum logic [2:0] {
        D_IDLE,
        D_ADDR,
        D_AACK,
        D_RX,
        D_RACK,
        D_TX,
        D_TACK
    } tssp_dst_t;

    typedef struct packed {
        logic sclS1;
        logic sclS2;
        logic sclP;
        logic sdaS1;
        logic sdaS2;
        logic sdaP;
        logic [2:0] asy1;
        logic [2:0] asy2;
        tssp_dst_t st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic rw;
        logic first;
        logic half;
        logic [1:0] ptr;
        logic [15:0] temp;
        logic [7:0] setr;
        logic [15:0] hyst;
        logic [15:0] upper;
        logic sdaOe;
        logic alert;
        logic [23:0] convCnt;
        logic convStrobe;
    } tssp_dev_t;

    tssp_dev_t q;
    tssp_dev_t n;
    logic rise;
    logic fall;
    logic startEv;
    logic stopEv;
    logic [23:0] convLimit;
    logic [7:0] txFirst;
    logic [7:0] txNext;

    // Only the second stage and its delayed copy feed the detectors
    assign rise = q.sclS2 && !q.sclP;
    assign fall = !q.sclS2 && q.sclP;
    assign startEv = q.sclS2 && q.sclP && q.sdaP && !q.sdaS2;
    assign stopEv = q.sclS2 && q.sclP && !q.sdaP && q.sdaS2;
    assign convLimit = 24'(CONV_BASE_CYC) << q.setr[tssp_pkg::RES_POS +: 2];

    function automatic logic [7:0] readByte(input logic [1:0] p, input logic lo,
        input tssp_dev_t s);
        logic [7:0] r;
        r = 8'h00;
        case (p)
            tssp_pkg::PTR_TEMP: r = lo ? s.temp[7:0] : s.temp[15:8];
            tssp_pkg::PTR_SET: r = s.setr;
            tssp_pkg::PTR_HYST: r = lo ? s.hyst[7:0] : s.hyst[15:8];
            tssp_pkg::PTR_UPPER: r = lo ? s.upper[7:0] : s.upper[15:8];
            default: r = 8'h00;
        endcase
        return r;
    endfunction

    assign txFirst = readByte(q.ptr, 1'b0, q);
    assign txNext = readByte(q.ptr, q.half, q);

    always_comb
    begin
        n = q;
        n.sclS1 = link.scl;
        n.sclS2 = q.sclS1;
        n.sclP = q.sclS2;
        n.sdaS1 = link.sda;
        n.sdaS2 = q.sdaS1;
        n.sdaP = q.sdaS2;
        n.asy1 = addrSelect;
        n.asy2 = q.asy1;
        n.convStrobe = 1'b0;
        // Result is replaced whole, but a bus read fetches each byte live, so its two bytes can come from two results
        if (q.convCnt >= convLimit - 24'h1)
        begin
            n.convCnt = 24'h0;
            n.temp = convData;
            n.convStrobe = 1'b1;
            if ($signed(convData) > $signed(q.upper))
            begin
                n.alert = 1'b1;
            end
            else if ($signed(convData) < $signed(q.hyst))
            begin
                n.alert = 1'b0;
            end
        end
        else
        begin
            n.convCnt = q.convCnt + 24'h1;
        end
        if (startEv)
        begin
            n.st = D_ADDR;
            n.cnt = 4'h0;
            n.sdaOe = 1'b0;
        end
        else if (stopEv)
        begin
            n.st = D_IDLE;
            n.sdaOe = 1'b0;
        end
        else
        begin
            case (q.st)
                D_IDLE:
                begin
                    n.sdaOe = 1'b0;
                end
                D_ADDR:
                begin
                    if (rise)
                    begin
                        n.sh = {q.sh[6:0], q.sdaS2};
                        n.cnt = q.cnt + 4'h1;
                    end
                    else if (fall && q.cnt == tssp_pkg::BIT_LAST)
                    begin
                        if (q.sh[7:1] == {tssp_pkg::ADDR_FIXED, q.asy2})
                        begin
                            n.rw = q.sh[0];
                            n.sdaOe = 1'b1;
                            n.first = 1'b1;
                            n.half = 1'b0;
                            n.st = D_AACK;
                        end
                        else
                        begin
                            n.st = D_IDLE;
                        end
                    end
                end
                D_AACK:
                begin
                    if (fall)
                    begin
                        n.cnt = 4'h0;
                        if (q.rw)
                        begin
                            n.sh = txFirst;
                            n.half = 1'b1;
                            n.sdaOe = !txFirst[7];
                            n.st = D_TX;
                        end
                        else
                        begin
                            n.sdaOe = 1'b0;
                            n.st = D_RX;
                        end
                    end
                end
                D_RX:
                begin
                    if (rise)
                    begin
                        n.sh = {q.sh[6:0], q.sdaS2};
                        n.cnt = q.cnt + 4'h1;
                    end
                    else if (fall && q.cnt == tssp_pkg::BIT_LAST)
                    begin
                        n.sdaOe = 1'b1;
                        n.st = D_RACK;
                        if (q.first)
                        begin
                            // Upper pointer bits are dropped, so higher pointers alias onto the four registers
                            n.ptr = q.sh[1:0];
                            n.first = 1'b0;
                            n.half = 1'b0;
                        end
                        else
                        begin
                            n.half = 1'b1;
                            case (q.ptr)
                                tssp_pkg::PTR_SET: n.setr = q.sh;
                                tssp_pkg::PTR_HYST:
                                begin
                                    if (q.half)
                                    begin
                                        n.hyst[7:0] = q.sh;
                                    end
                                    else
                                    begin
                                        n.hyst[15:8] = q.sh;
                                    end
                                end
                                tssp_pkg::PTR_UPPER:
                                begin
                                    if (q.half)
                                    begin
                                        n.upper[7:0] = q.sh;
                                    end
                                    else
                                    begin
                                        n.upper[15:8] = q.sh;
                                    end
                                end
                                default: n.half = 1'b1;
                            endcase
                        end
                    end
                end
                D_RACK:
                begin
                    if (fall)
                    begin
                        n.sdaOe = 1'b0;
                        n.cnt = 4'h0;
                        n.st = D_RX;
                    end
                end
                D_TX:
                begin
                    if (rise)
                    begin
                        n.cnt = q.cnt + 4'h1;
                    end
                    else if (fall)
                    begin
                        if (q.cnt == tssp_pkg::BIT_LAST)
                        begin
                            n.sdaOe = 1'b0;
                            n.st = D_TACK;
                        end
                        else
                        begin
                            n.sh = {q.sh[6:0], 1'b0};
                            n.sdaOe = !q.sh[6];
                        end
                    end
                end
                D_TACK:
                begin
                    if (rise)
                    begin
                        if (q.sdaS2)
                        begin
                            n.st = D_IDLE;
                        end
                        else
                        begin
                            n.cnt = tssp_pkg::ACKED_MARK;
                        end
                    end
                    else if (fall && q.cnt == tssp_pkg::ACKED_MARK)
                    begin
                        // Same register again: the two halves alternate
                        n.sh = txNext;
                        n.half = !q.half;
                        n.sdaOe = !txNext[7];
                        n.cnt = 4'h0;
                        n.st = D_TX;
                    end
                end
                default:
                begin
                    n.st = D_IDLE;
                    n.sdaOe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            q <= '0;
            q.ptr <= tssp_pkg::PTR_RST;
            q.temp <= tssp_pkg::REG16_RST;
            q.setr <= tssp_pkg::REG8_RST;
            q.hyst <= tssp_pkg::REG16_RST;
            q.upper <= tssp_pkg::REG16_RST;
        end
        else
        begin
            q <= n;
        end
    end

    assign link.sdaDevOut = 1'b0;
    assign link.sdaDevOe = q.sdaOe;
    assign convStrobe = q.convStrobe;
    assign alert = q.alert;
    assign settings = q.setr;
endmodule // tssp_device

//--- src/tssp_host.sv
// Host end: two-wire bus master ordered through Wishbone classic registers.
// Makes SCL itself by dividing mclk; samples SDA through two flip-flops.
`timescale 1ns/10ps
module tssp_host #(
    parameter int QUARTER_CYC = tssp_pkg::SCL_QUARTER_CYC
) (
    input wire logic mclk,
    input wire logic sys_rst,
    tssp_if.host link,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    typedef enum logic [1:0] {
        H_IDLE,
        H_START,
        H_BIT,
        H_STOP
    } tssp_hst_t;

    typedef struct packed {
        logic ack;
        logic [31:0] datR;
        logic [15:0] tgt;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic busy;
        logic nak;
        logic rd;
        logic withPtr;
        logic [1:0] nData;
        tssp_hst_t st;
        logic [1:0] qtr;
        logic [7:0] tick;
        logic [3:0] bitN;
        logic [2:0] byteN;
        logic [7:0] tx;
        logic [7:0] rxs;
        logic sclLow;
        logic sdaLow;
        logic sdaS1;
        logic sdaS2;
    } tssp_host_t;

    tssp_host_t q;
    tssp_host_t n;
    logic req;
    logic qtick;
    logic isRx;
    logic lastByte;
    logic [2:0] total;

    assign req = wb_cyc_i && wb_stb_i;
    assign qtick = q.tick == 8'(QUARTER_CYC - 1);
    assign isRx = q.rd && q.byteN != 3'h0;
    assign total = 3'h1 + 3'(q.nData) + ((q.withPtr && !q.rd) ? 3'h1 : 3'h0);
    assign lastByte = q.byteN == total - 3'h1;

    // Byte order: address, pointer if asked on a write (never on a read), then data high before low
    function automatic logic [7:0] txByte(input logic [2:0] idx, input tssp_host_t s);
        logic [7:0] r;
        logic [2:0] k;
        k = idx - 3'h1 - ((s.withPtr && !s.rd) ? 3'h1 : 3'h0);
        if (idx == 3'h0)
        begin
            r = {s.tgt[6:0], s.rd};
        end
        else if (s.withPtr && !s.rd && idx == 3'h1)
        begin
            // Upper pointer bits forced to zero so hidden registers stay unreachable
            r = {6'h00, s.tgt[tssp_pkg::TGT_PTR +: 2]};
        end
        else
        begin
            r = (k == 3'h0) ? s.wdata[15:8] : s.wdata[7:0];
        end
        return r;
    endfunction

    always_comb
    begin
        n = q;
        n.sdaS1 = link.sda;
        n.sdaS2 = q.sdaS1;
        n.ack = req && !q.ack;
        if (req && !q.ack)
        begin
            case (wb_adr_i)
                tssp_pkg::WB_CTRL: n.datR = {27'h0, q.nData, q.withPtr, q.rd, q.busy};
                tssp_pkg::WB_TARGET: n.datR = {16'h0, q.tgt};
                tssp_pkg::WB_WDATA: n.datR = {16'h0, q.wdata};
                tssp_pkg::WB_RDATA: n.datR = {16'h0, q.rdata};
                tssp_pkg::WB_STATUS: n.datR = {30'h0, q.nak, q.busy};
                default: n.datR = 32'h0;
            endcase
        end
        // Writes land on the edge where the master sees ack
        if (req && q.ack && wb_we_i)
        begin
            case (wb_adr_i)
                tssp_pkg::WB_CTRL:
                begin
                    if (wb_sel_i[0] && wb_dat_i[tssp_pkg::CTRL_GO] && !q.busy)
                    begin
                        n.rd = wb_dat_i[tssp_pkg::CTRL_READ];
                        n.withPtr = wb_dat_i[tssp_pkg::CTRL_PTR];
                        n.nData = wb_dat_i[tssp_pkg::CTRL_CNT +: 2];
                        n.busy = 1'b1;
                        n.nak = 1'b0;
                        n.st = H_START;
                        n.qtr = 2'h0;
                        n.tick = 8'h0;
                    end
                end
                tssp_pkg::WB_TARGET:
                begin
                    n.tgt[7:0] = wb_sel_i[0] ? wb_dat_i[7:0] : q.tgt[7:0];
                    n.tgt[15:8] = wb_sel_i[1] ? wb_dat_i[15:8] : q.tgt[15:8];
                end
                tssp_pkg::WB_WDATA:
                begin
                    n.wdata[7:0] = wb_sel_i[0] ? wb_dat_i[7:0] : q.wdata[7:0];
                    n.wdata[15:8] = wb_sel_i[1] ? wb_dat_i[15:8] : q.wdata[15:8];
                end
                default: n.tick = q.tick;
            endcase
        end
        if (q.st != H_IDLE)
        begin
            n.tick = qtick ? 8'h0 : q.tick + 8'h1;
        end
        if (q.st != H_IDLE && qtick)
        begin
            n.qtr = q.qtr + 2'h1;
            case (q.st)
                H_START:
                begin
                    case (q.qtr)
                        2'h0: n.sdaLow = 1'b0;
                        2'h1: n.sdaLow = 1'b1;
                        2'h2: n.sclLow = 1'b1;
                        default:
                        begin
                            n.st = H_BIT;
                            n.bitN = 4'h0;
                            n.byteN = 3'h0;
                            n.tx = txByte(3'h0, q);
                        end
                    endcase
                end
                H_BIT:
                begin
                    case (q.qtr)
                        2'h0:
                        begin
                            if (q.bitN < tssp_pkg::BIT_LAST)
                            begin
                                n.sdaLow = isRx ? 1'b0 : !q.tx[7];
                            end
                            else
                            begin
                                n.sdaLow = isRx && !lastByte;
                            end
                        end
                        2'h1: n.sclLow = 1'b0;
                        2'h2:
                        begin
                            if (q.bitN < tssp_pkg::BIT_LAST && isRx)
                            begin
                                n.rxs = {q.rxs[6:0], q.sdaS2};
                            end
                            else if (q.bitN == tssp_pkg::BIT_LAST && !isRx && q.sdaS2)
                            begin
                                n.nak = 1'b1;
                            end
                        end
                        default:
                        begin
                            n.sclLow = 1'b1;
                            if (q.bitN == tssp_pkg::BIT_LAST)
                            begin
                                if (isRx)
                                begin
                                    n.rdata = {q.rdata[7:0], q.rxs};
                                end
                                if (q.nak || lastByte)
                                begin
                                    n.st = H_STOP;
                                end
                                else
                                begin
                                    n.byteN = q.byteN + 3'h1;
                                    n.tx = txByte(q.byteN + 3'h1, q);
                                    n.bitN = 4'h0;
                                end
                            end
                            else
                            begin
                                n.tx = {q.tx[6:0], 1'b0};
                                n.bitN = q.bitN + 4'h1;
                            end
                        end
                    endcase
                end
                H_STOP:
                begin
                    case (q.qtr)
                        2'h0: n.sdaLow = 1'b1;
                        2'h1: n.sclLow = 1'b0;
                        2'h2: n.sdaLow = 1'b0;
                        default:
                        begin
                            n.st = H_IDLE;
                            n.busy = 1'b0;
                        end
                    endcase
                end
                default: n.st = H_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            q <= '0;
        end
        else
        begin
            q <= n;
        end
    end

    assign link.sclOut = 1'b0;
    assign link.sclOe = q.sclLow;
    assign link.sdaHostOut = 1'b0;
    assign link.sdaHostOe = q.sdaLow;
    assign wb_dat_o = q.datR;
    assign wb_ack_o = q.ack;
endmodule // tssp_host

//--- tb/temp_sensor_serial_slave_port_test.sv
// Both ends joined on one link; software side driven over Wishbone.
// Assumes short conversion and bit periods set through parameters.
`timescale 1ns/10ps
module temp_sensor_serial_slave_port_test;
    localparam logic [6:0] DEV = {tssp_pkg::ADDR_FIXED, 3'h5};
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic wbReq = 1'b0;
    logic wbWe = 1'b0;
    logic [7:0] wbAdr = 8'h00;
    logic [31:0] wbDat = 32'h0;
    logic [31:0] wbDatO;
    logic [31:0] wbQ;
    logic wbAck;
    logic nak;
    logic [15:0] convData = 16'h1940;
    logic convStrobe;
    logic alert;
    logic [7:0] settings;
    logic [15:0] wv [4] = '{16'h0000, 16'h1B00, 16'h0A80, 16'h1900};
    int error_cnt = 0;
    int checks_done = 0;
    tssp_if link();
    tssp_device #(.CONV_BASE_CYC(50)) i_tssp_device (.mclk(mclk), .sys_rst(sys_rst),
        .link(link), .addrSelect(3'h5), .convData(convData), .convStrobe(convStrobe),
        .alert(alert), .settings(settings));
    tssp_host #(.QUARTER_CYC(4)) i_tssp_host (.mclk(mclk), .sys_rst(sys_rst), .link(link),
        .wb_cyc_i(wbReq), .wb_stb_i(wbReq), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
        .wb_dat_i(wbDat), .wb_sel_i(4'hF), .wb_dat_o(wbDatO), .wb_ack_o(wbAck));
    tssp_props i_tssp_props (.mclk(mclk), .sys_rst(sys_rst), .sclOe(link.sclOe),
        .sdaHostOe(link.sdaHostOe), .sdaDevOe(link.sdaDevOe), .scl(link.scl), .sda(link.sda));
    always #20 mclk = ~mclk;
    task conclude;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            $display("ERROR %s expected %h seen %h", n, e, g);
            error_cnt++;
        end
    endtask
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        wbReq <= 1'b1;
        wbWe <= w;
        wbAdr <= a;
        wbDat <= d;
        // Ack and read data are taken at the rising edge that sees ack high
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (wbAck !== 1'b1 && n < 50);
        wbQ = wbDatO;
        wbReq <= 1'b0;
        if (n >= 50)
        begin
            $display("ERROR wb ack expected 1 seen 0");
            error_cnt++;
            conclude();
        end
    endtask
    // One full link transfer: set target and data, start, wait for idle, fetch result
    task xfer(input logic [4:0] ctl, input logic [6:0] a, input logic [7:0] p,
        input logic [15:0] wd);
        int n;
        n = 0;
        wb(1'b1, tssp_pkg::WB_TARGET, {16'h0000, p, 1'b0, a});
        wb(1'b1, tssp_pkg::WB_WDATA, {16'h0000, wd});
        wb(1'b1, tssp_pkg::WB_CTRL, {27'h0, ctl});
        do
        begin
            wb(1'b0, tssp_pkg::WB_STATUS, 32'h0);
            n++;
        end
        while (wbQ[tssp_pkg::STAT_BUSY] !== 1'b0 && n < 1000);
        nak = wbQ[tssp_pkg::STAT_NAK];
        wb(1'b0, tssp_pkg::WB_RDATA, 32'h0);
        if (n >= 1000)
        begin
            $display("ERROR busy expected 0 seen 1");
            error_cnt++;
            conclude();
        end
    endtask
    task t_regs;
        for (int p = 1; p < 4; p++)
        begin
            xfer({(p == 1) ? 2'h1 : 2'h2, 3'b101}, DEV, 8'(p), wv[p]);
            chk("write nak", 1'b0, nak);
            xfer(5'b00101, DEV, 8'(p), 16'h0000);
            xfer(5'b10011, DEV, 8'h00, 16'h0000);
            chk("readback", (p == 1) ? 16'h1B1B : wv[p], wbQ[15:0]);
        end
        chk("settings", 8'h1B, settings);
        $display("t_regs done");
    endtask
    task t_result;
        xfer(5'b10101, DEV, 8'h00, 16'hFFFF);
        chk("ro write nak", 1'b0, nak);
        xfer(5'b10011, DEV, 8'h00, 16'h0000);
        chk("result", 16'h1940, wbQ[15:0]);
        chk("alert high", 1'b1, alert);
        convData <= 16'h0500;
        xfer(5'b10011, DEV, 8'h00, 16'h0000);
        chk("result", 16'h0500, wbQ[15:0]);
        chk("alert low", 1'b0, alert);
        $display("t_result done");
    endtask
    task t_badaddr;
        xfer(5'b00101, {tssp_pkg::ADDR_FIXED, 3'h4}, 8'h03, 16'h0000);
        chk("foreign nak", 1'b1, nak);
        xfer(5'b10011, DEV, 8'h00, 16'h0000);
        chk("ptr kept", 16'h0500, wbQ[15:0]);
        $display("t_badaddr done");
    endtask
    // Any 200-cycle window holds a fixed number of strobes once the period is steady
    task t_conv;
        int k;
        k = 0;
        repeat (200)
        begin
            @(posedge mclk);
            if (convStrobe === 1'b1)
                k++;
        end
        chk("strobes 1x", 32'h4, k);
        xfer(5'b01101, DEV, 8'h01, 16'h3B00);
        chk("settings", 8'h3B, settings);
        k = 0;
        repeat (200)
        begin
            @(posedge mclk);
            if (convStrobe === 1'b1)
                k++;
        end
        chk("strobes 2x", 32'h2, k);
        $display("t_conv done");
    endtask
    initial
    begin
        repeat (5) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge mclk);
        chk("reset alert", 1'b0, alert);
        chk("reset settings", 8'h00, settings);
        t_regs();
        t_result();
        t_badaddr();
        t_conv();
        conclude();
    end
endmodule // temp_sensor_serial_slave_port_test

//--- tb/tssp_props.sv
// Concurrent checks on the two-wire link joining the host and device ends.
// Assumes the host runs with a quarter bit period of 4 mclk cycles.
`timescale 1ns/10ps
module tssp_props (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic sclOe,
    input wire logic sdaHostOe,
    input wire logic sdaDevOe,
    input wire logic scl,
    input wire logic sda
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    property p_dev_chg_low;
        $changed(sdaDevOe) |-> !scl;
    endproperty
    a_dev_chg_low: assert property (p_dev_chg_low) else $error("device moved sda with scl high");
    property p_dev_hold;
        $rose(scl) && sdaDevOe |=> sdaDevOe [*3];
    endproperty
    a_dev_hold: assert property (p_dev_hold) else $error("device low not held over scl high");
    property p_stop_rel;
        $rose(sda) && scl |=> !sdaDevOe [*4];
    endproperty
    a_stop_rel: assert property (p_stop_rel) else $error("device drives after stop");
    property p_start_rel;
        $fell(sda) && scl |=> !sdaDevOe [*4];
    endproperty
    a_start_rel: assert property (p_start_rel) else $error("device drives after start");
    property p_start_clk;
        $fell(sda) && scl |-> ##[1:8] !scl;
    endproperty
    a_start_clk: assert property (p_start_clk) else $error("no clocking after start");
    property p_stop_idle;
        $rose(sda) && scl |=> (scl && sda) [*4];
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("bus not idle after stop");
    property p_scl_low;
        $fell(scl) |-> !scl [*4];
    endproperty
    a_scl_low: assert property (p_scl_low) else $error("scl low phase too short");
    property p_host_chg;
        $changed(sdaHostOe) && scl |-> $past(scl, 3);
    endproperty
    a_host_chg: assert property (p_host_chg) else $error("host moved sda inside a bit");
endmodule // tssp_props
